// file: design/uart_ctl.sv
// Serial line controller with multiprocessor filter and AHB-Lite registers
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps
`default_nettype none
module uart_ctl
   import uart_ctl_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [13:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout_q,
   output logic             hresp_q,
   output logic [31:0]      hrdata_q,
   // Serial line
   input  wire logic        rxd,
   input  wire logic        cts_n,
   output logic             txd_q,
   output logic             drive_en_q,
   // Receive request to the interrupt controller
   output logic             rx_irq_q
);

   typedef enum logic [4:0] {
      TX_IDLE  = 5'b00001,
      TX_START = 5'b00010,
      TX_DATA  = 5'b00100,
      TX_EXTRA = 5'b01000,
      TX_STOP  = 5'b10000
   } tx_state_type;

   typedef enum logic [4:0] {
      RX_IDLE  = 5'b00001,
      RX_START = 5'b00010,
      RX_DATA  = 5'b00100,
      RX_EXTRA = 5'b01000,
      RX_STOP  = 5'b10000
   } rx_state_type;

   ahb_req_type  req_q;
   ctl0_type     ctl0_q;
   ctl1_type     ctl1_q;
   logic [7:0]   match_q, brh_q, brl_q;
   logic [7:0]   rd_data;
   logic         accept, wr, rd, rd_rx;
   logic         tick;
   logic [1:0]   rxd_s, cts_s;
   logic [7:0]   tx_hold_q, tx_sh_q;
   logic         tx_full_q, tx_load, tx_go, tx_extra_q;
   logic         tx_has_extra, tx_bit_done, stop2_q;
   logic [2:0]   tx_bit_q;
   logic [3:0]   tx_cnt_q;
   tx_state_type tx_state_q;
   rx_state_type rx_state_q;
   logic         rx_in, rx_done, rx_extra_q, rx_has_extra;
   logic [7:0]   rx_sh_q, rx_data_q;
   logic [2:0]   rx_bit_q;
   logic [3:0]   rx_cnt_q;
   logic         rx_valid_q, par_err_q, frm_err_q;
   logic         frame_start_q, rx_mp_q, new_frame_q, addr_hit_q;
   logic         is_addr, is_match, irq_hit;
   logic [1:0]   mp_mode;

   // ---------------------------------------------------------------
   // Bus slave: one wait state, then answer
   // ---------------------------------------------------------------
   assign accept = hsel & hready & (htrans == HTRANS_NSEQ);
   assign wr     = req_q.valid & req_q.write;
   assign rd     = req_q.valid & ~req_q.write;
   assign rd_rx  = rd & (req_q.idx == IDX_DATA);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_q       <= '0;
         hreadyout_q <= 1'b1;
         hresp_q     <= HRESP_OKAY;
      end else if (req_q.valid) begin
         req_q.valid <= 1'b0;
         hreadyout_q <= 1'b1;
      end else if (accept) begin
         req_q       <= '{idx: haddr[13:2], write: hwrite, valid: 1'b1};
         hreadyout_q <= 1'b0;
      end
   end

   always_comb begin
      case (req_q.idx)
         IDX_DATA:  rd_data = rx_data_q;
         IDX_STAT:  rd_data = {1'b0, rx_mp_q, frame_start_q, frm_err_q, par_err_q,
                               tx_state_q == TX_IDLE, ~tx_full_q, rx_valid_q};
         IDX_CTL0:  rd_data = ctl0_q;
         IDX_CTL1:  rd_data = ctl1_q;
         IDX_MATCH: rd_data = match_q;
         IDX_BRH:   rd_data = brh_q;
         IDX_BRL:   rd_data = brl_q;
         default:   rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         hrdata_q <= 32'h0;
      end else if (rd) begin
         hrdata_q <= {24'h0, rd_data};
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl0_q  <= CTL_RESET;
         ctl1_q  <= CTL_RESET;
         match_q <= MATCH_RESET;
         brh_q   <= BR_RESET;
         brl_q   <= BR_RESET;
      end else if (wr) begin
         case (req_q.idx)
            IDX_CTL0:  ctl0_q  <= hwdata[7:0];
            IDX_CTL1:  ctl1_q  <= hwdata[7:0];
            IDX_MATCH: match_q <= hwdata[7:0];
            IDX_BRH:   brh_q   <= hwdata[7:0];
            IDX_BRL:   brl_q   <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   assign mp_mode = {ctl1_q.mode_hi, ctl1_q.mode_lo};

   baud_tick #(.DIV_W(16)) u_baud (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .divisor  ({brh_q, brl_q}),
      .tick_q   (tick)
   );

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rxd_s <= 2'h3;
         cts_s <= 2'h3;
      end else begin
         rxd_s <= {rxd_s[0], rxd};
         cts_s <= {cts_s[0], cts_n};
      end
   end

   // ---------------------------------------------------------------
   // Transmitter
   // ---------------------------------------------------------------
   assign tx_go        = ctl0_q.transmit_enable
                       & (~ctl0_q.cts_gate_enable | ~cts_s[1]);
   assign tx_load      = (tx_state_q == TX_IDLE) & tx_full_q & tx_go
                       & ~ctl0_q.break_request;
   assign tx_has_extra = ctl1_q.nine_bit_enable | ctl0_q.parity_enable;
   assign tx_bit_done  = tick & (tx_cnt_q == TICK_LAST);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_full_q <= 1'b0;
         tx_hold_q <= 8'h00;
      end else if (tx_load) begin
         tx_full_q <= 1'b0;
      end else if (wr && req_q.idx == IDX_DATA && !tx_full_q) begin
         tx_full_q <= 1'b1;
         tx_hold_q <= hwdata[7:0];
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_cnt_q <= 4'h0;
      end else if (tx_state_q == TX_IDLE) begin
         tx_cnt_q <= 4'h0;
      end else if (tick) begin
         tx_cnt_q <= tx_cnt_q + 4'h1;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_state_q <= TX_IDLE;
         txd_q      <= 1'b1;
         tx_sh_q    <= 8'h00;
         tx_bit_q   <= 3'h0;
         tx_extra_q <= 1'b0;
         stop2_q    <= 1'b0;
      end else if (ctl0_q.break_request || !ctl0_q.transmit_enable) begin
         tx_state_q <= TX_IDLE;
         txd_q      <= ~ctl0_q.break_request;
      end else begin
         case (tx_state_q)
            TX_IDLE: begin
               txd_q <= 1'b1;
               if (tx_load) begin
                  tx_state_q <= TX_START;
                  txd_q      <= 1'b0;
                  tx_sh_q    <= tx_hold_q;
                  tx_bit_q   <= 3'h0;
                  stop2_q    <= ctl0_q.stop_select;
                  tx_extra_q <= ctl1_q.nine_bit_enable ? ctl1_q.tx_mp_bit
                              : (^tx_hold_q) ^ ctl0_q.parity_select;
               end
            end
            TX_START: if (tx_bit_done) begin
               tx_state_q <= TX_DATA;
               txd_q      <= tx_sh_q[0];
            end
            TX_DATA: if (tx_bit_done) begin
               if (tx_bit_q == LAST_BIT) begin
                  tx_state_q <= tx_has_extra ? TX_EXTRA : TX_STOP;
                  txd_q      <= tx_has_extra ? tx_extra_q : 1'b1;
               end else begin
                  tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                  txd_q    <= tx_sh_q[1];
                  tx_bit_q <= tx_bit_q + 3'h1;
               end
            end
            TX_EXTRA: if (tx_bit_done) begin
               tx_state_q <= TX_STOP;
               txd_q      <= 1'b1;
            end
            TX_STOP: if (tx_bit_done) begin
               if (stop2_q) begin
                  stop2_q <= 1'b0;
               end else begin
                  tx_state_q <= TX_IDLE;
               end
            end
            default: tx_state_q <= TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         drive_en_q <= 1'b0;
      end else begin
         drive_en_q <= (tx_state_q != TX_IDLE) ~^ ctl1_q.drive_enable_polarity;
      end
   end

   // ---------------------------------------------------------------
   // Receiver
   // ---------------------------------------------------------------
   assign rx_in        = ctl0_q.loopback_enable ? txd_q : rxd_s[1];
   assign rx_has_extra = ctl1_q.nine_bit_enable | ctl0_q.parity_enable;
   assign rx_done      = (rx_state_q == RX_STOP) & tick & (rx_cnt_q == TICK_LAST);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_state_q <= RX_IDLE;
         rx_cnt_q   <= 4'h0;
         rx_bit_q   <= 3'h0;
         rx_sh_q    <= 8'h00;
         rx_extra_q <= 1'b0;
      end else if (!ctl0_q.receive_enable) begin
         rx_state_q <= RX_IDLE;
      end else begin
         if (tick) begin
            rx_cnt_q <= rx_cnt_q + 4'h1;
         end
         case (rx_state_q)
            RX_IDLE: if (!rx_in) begin
               rx_state_q <= RX_START;
               rx_cnt_q   <= 4'h0;
            end
            RX_START: if (tick && rx_cnt_q == TICK_MID) begin
               rx_state_q <= rx_in ? RX_IDLE : RX_DATA;
               rx_cnt_q   <= 4'h0;
               rx_bit_q   <= 3'h0;
            end
            RX_DATA: if (tick && rx_cnt_q == TICK_LAST) begin
               rx_sh_q  <= {rx_in, rx_sh_q[7:1]};
               rx_bit_q <= rx_bit_q + 3'h1;
               if (rx_bit_q == LAST_BIT) begin
                  rx_state_q <= rx_has_extra ? RX_EXTRA : RX_STOP;
               end
            end
            RX_EXTRA: if (tick && rx_cnt_q == TICK_LAST) begin
               rx_extra_q <= rx_in;
               rx_state_q <= RX_STOP;
            end
            RX_STOP: if (tick && rx_cnt_q == TICK_LAST) begin
               rx_state_q <= RX_IDLE;
            end
            default: rx_state_q <= RX_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Multiprocessor filter
   // ---------------------------------------------------------------
   assign is_addr  = ctl1_q.nine_bit_enable & rx_extra_q;
   assign is_match = (rx_sh_q == match_q);

   always_comb begin
      if (!ctl1_q.nine_bit_enable) begin
         irq_hit = 1'b1;
      end else begin
         case (mp_mode)
            MP_ALL:        irq_hit = 1'b1;
            MP_ADDR:       irq_hit = is_addr;
            MP_MATCH_ALL:  irq_hit = is_addr ? is_match : addr_hit_q;
            MP_MATCH_DATA: irq_hit = ~is_addr & addr_hit_q;
            default:       irq_hit = 1'b0;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_hit_q  <= 1'b0;
         new_frame_q <= 1'b0;
         rx_irq_q    <= 1'b0;
      end else begin
         rx_irq_q <= rx_done & irq_hit;
         if (rx_done) begin
            new_frame_q <= is_addr;
            if (is_addr) begin
               addr_hit_q <= is_match;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Received byte and status; a new byte wins over a clearing read
   // ---------------------------------------------------------------
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_data_q     <= 8'h00;
         rx_valid_q    <= 1'b0;
         par_err_q     <= 1'b0;
         frm_err_q     <= 1'b0;
         frame_start_q <= 1'b0;
         rx_mp_q       <= 1'b0;
      end else if (rx_done) begin
         rx_data_q     <= rx_sh_q;
         rx_valid_q    <= 1'b1;
         frm_err_q     <= ~rx_in;
         par_err_q     <= ~ctl1_q.nine_bit_enable & ctl0_q.parity_enable
                        & ((^{rx_sh_q, rx_extra_q}) != ctl0_q.parity_select);
         frame_start_q <= ~is_addr & new_frame_q;
         rx_mp_q       <= is_addr;
      end else if (rd_rx) begin
         rx_valid_q    <= 1'b0;
         par_err_q     <= 1'b0;
         frm_err_q     <= 1'b0;
         frame_start_q <= 1'b0;
         rx_mp_q       <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   property p_break;
      ctl0_q.break_request |=> !txd_q && tx_state_q == TX_IDLE;
   endproperty
   a_break: assert property (p_break) else $error("break did not hold line low");

   property p_tx_off;
      !ctl0_q.transmit_enable |=> tx_state_q == TX_IDLE;
   endproperty
   a_tx_off: assert property (p_tx_off) else $error("transmitter ran while disabled");

   property p_cts_free;
      tx_state_q == TX_IDLE && tx_full_q && ctl0_q.transmit_enable
      && !ctl0_q.cts_gate_enable && !ctl0_q.break_request |=> tx_state_q == TX_START;
   endproperty
   a_cts_free: assert property (p_cts_free) else $error("cts blocked ungated transmit");

   property p_rx_off;
      !ctl0_q.receive_enable |=> rx_state_q == RX_IDLE ##1 !rx_irq_q;
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("receiver ran while disabled");

   property p_start_low;
      tx_state_q == TX_START |-> !txd_q;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not low");

   property p_stop_high;
      tx_state_q == TX_STOP |-> txd_q;
   endproperty
   a_stop_high: assert property (p_stop_high) else $error("stop bit not high");

   property p_mode00;
      rx_done && (!ctl1_q.nine_bit_enable || mp_mode == MP_ALL) |=> rx_irq_q;
   endproperty
   a_mode00: assert property (p_mode00) else $error("byte raised no request");

   property p_mode01;
      rx_done && is_addr == 1'b0 && ctl1_q.nine_bit_enable && mp_mode == MP_ADDR
      |=> !rx_irq_q;
   endproperty
   a_mode01: assert property (p_mode01) else $error("data byte raised request");

   property p_mode11;
      rx_done && is_addr && mp_mode == MP_MATCH_DATA |=> !rx_irq_q;
   endproperty
   a_mode11: assert property (p_mode11) else $error("address byte raised request");

   property p_loop;
      ctl0_q.loopback_enable && ctl0_q.receive_enable && rx_state_q == RX_IDLE
      && !txd_q |=> rx_state_q == RX_START;
   endproperty
   a_loop: assert property (p_loop) else $error("loopback not seen by receiver");

   property p_rd_clear;
      rd_rx && !rx_done |=> !frame_start_q && !rx_mp_q && !rx_valid_q;
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("read did not clear flags");

   c_tx_done:  cover property (tx_state_q == TX_STOP ##1 tx_state_q == TX_IDLE);
   c_rx_match: cover property (rx_done && is_addr && is_match && mp_mode == MP_MATCH_ALL);
   c_break:    cover property ($rose(ctl0_q.break_request));

endmodule : uart_ctl
`default_nettype wire

// file: design/uart_ctl_pkg.sv
// Register map, field layouts and constants of the serial line controller
package uart_ctl_pkg;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [11:0] IDX_DATA  = 12'hf40;
   localparam logic [11:0] IDX_STAT  = 12'hf41;
   localparam logic [11:0] IDX_CTL0  = 12'hf42;
   localparam logic [11:0] IDX_CTL1  = 12'hf43;
   localparam logic [11:0] IDX_MATCH = 12'hf45;
   localparam logic [11:0] IDX_BRH   = 12'hf46;
   localparam logic [11:0] IDX_BRL   = 12'hf47;

   // ---------------------------------------------------------------
   // Reset values and counts
   // ---------------------------------------------------------------
   localparam logic [7:0]  CTL_RESET   = 8'h00;
   localparam logic [7:0]  MATCH_RESET = 8'h00;
   localparam logic [7:0]  BR_RESET    = 8'hff;
   localparam logic [3:0]  TICK_LAST   = 4'hf;
   localparam logic [3:0]  TICK_MID    = 4'h7;
   localparam logic [2:0]  LAST_BIT    = 3'h7;
   localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
   localparam logic        HRESP_OKAY  = 1'b0;

   // ---------------------------------------------------------------
   // Multiprocessor receive filter modes
   // ---------------------------------------------------------------
   localparam logic [1:0]  MP_ALL        = 2'h0;
   localparam logic [1:0]  MP_ADDR       = 2'h1;
   localparam logic [1:0]  MP_MATCH_ALL  = 2'h2;
   localparam logic [1:0]  MP_MATCH_DATA = 2'h3;

   // ---------------------------------------------------------------
   // Status register bit positions
   // ---------------------------------------------------------------
   localparam int ST_RX_VALID = 0;
   localparam int ST_TX_EMPTY = 1;
   localparam int ST_TX_IDLE  = 2;
   localparam int ST_PAR_ERR  = 3;
   localparam int ST_FRM_ERR  = 4;
   localparam int ST_FRAME    = 5;
   localparam int ST_MP_BIT   = 6;

   typedef struct packed {
      logic transmit_enable;
      logic receive_enable;
      logic cts_gate_enable;
      logic parity_enable;
      logic parity_select;
      logic break_request;
      logic stop_select;
      logic loopback_enable;
   } ctl0_type;

   typedef struct packed {
      logic mode_hi;
      logic nine_bit_enable;
      logic mode_lo;
      logic tx_mp_bit;
      logic drive_enable_polarity;
      logic baud_gen_control;
      logic rx_data_irq_select;
      logic infrared_codec_on;
   } ctl1_type;

   typedef struct packed {
      logic [11:0] idx;
      logic        write;
      logic        valid;
   } ahb_req_type;

endpackage : uart_ctl_pkg

// file: design/baud_tick.sv
// Sixteen-times oversampling tick divider
`timescale 1ns/100ps
`default_nettype none
module baud_tick #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   // Divisor and tick
   input  wire logic [DIV_W-1:0] divisor,
   output logic                  tick_q
);

   logic [DIV_W-1:0] cnt_q;

   // Zero or one divisor gives a tick every cycle
   // Reload early when divisor drops below count, so a new rate acts at once
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end else if ((cnt_q <= DIV_W'(1)) || (cnt_q > divisor)) begin
         cnt_q  <= divisor;
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q - DIV_W'(1);
         tick_q <= 1'b0;
      end
   end

endmodule : baud_tick
`default_nettype wire

// file: test/remote_line_model.sv
// Remote serial station on the far side of the line
`timescale 1ns/100ps
`default_nettype none
module remote_line_model (
   // Clock
   input  wire logic core_clk,
   // Line
   input  wire logic txd_q,
   output logic      rxd
);
   // ---------------------------------------------------------------
   // Frame send and capture
   // ---------------------------------------------------------------
   localparam int BIT_CYC = 16;
   initial rxd = 1'b1;

   // Start low, bits LSB first, stop high, then line idles high
   task automatic send(input logic [8:0] v, input int nb);
      rxd <= 1'b0;
      repeat (BIT_CYC) @(posedge core_clk);
      for (int i = 0; i < nb; i++) begin
         rxd <= v[i];
         repeat (BIT_CYC) @(posedge core_clk);
      end
      rxd <= 1'b1;
      repeat (2 * BIT_CYC) @(posedge core_clk);
   endtask : send

   // Bits after the start bit, sampled mid-bit
   task automatic recv(output logic [10:0] v, input int nb);
      int w;
      v = '1;
      w = 0;
      while (txd_q !== 1'b0 && w < 4000) begin
         @(posedge core_clk);
         w++;
      end
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < nb; i++) begin
         repeat (BIT_CYC) @(posedge core_clk);
         v[i] = txd_q;
      end
   endtask : recv
endmodule : remote_line_model
`default_nettype wire

// file: test/uart_ctl_tb_top.sv
// Self-checking bench for the serial line controller
`timescale 1ns/100ps
`default_nettype none
module uart_ctl_tb_top import uart_ctl_pkg::*; ;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic core_clk = 0, reset_n = 0, hsel = 0, hwrite = 0, cts_n = 1;
   logic hreadyout_q, hresp_q, txd_q, drive_en_q, rx_irq_q, rxd;
   logic [13:0] haddr = 0;
   logic [1:0]  htrans = 0;
   logic [31:0] hwdata = 0, hrdata_q, rd;
   logic [10:0] v;
   int          errors = 0, n_checks = 0, irq_cnt = 0;

   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) if (rx_irq_q === 1'b1) irq_cnt++;

   uart_ctl uut (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout_q), .hreadyout_q(hreadyout_q), .hresp_q(hresp_q),
      .hrdata_q(hrdata_q), .rxd(rxd), .cts_n(cts_n), .txd_q(txd_q),
      .drive_en_q(drive_en_q), .rx_irq_q(rx_irq_q));
   remote_line_model far (.core_clk(core_clk), .txd_q(txd_q), .rxd(rxd));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task bus(input logic [11:0] idx, input logic wr, input logic [7:0] wd);
      hsel <= 1'b1;
      htrans <= HTRANS_NSEQ;
      haddr <= {idx, 2'b00};
      hwrite <= wr;
      do @(posedge core_clk); while (hreadyout_q !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge core_clk); while (hreadyout_q !== 1'b1);
      rd = hrdata_q;
   endtask : bus

   task end_sim;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_sim

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_regs;
      bus(IDX_CTL0, 0, 0); chk(rd, 32'h0);
      chk({31'h0, hresp_q}, {31'h0, HRESP_OKAY});
      bus(IDX_CTL1, 0, 0); chk(rd, 32'h0);
      bus(IDX_MATCH, 0, 0); chk(rd, 32'h0);
      bus(IDX_BRH, 0, 0); chk(rd, 32'hff);
      bus(12'hf44, 0, 0); chk(rd, 32'h0);
      bus(IDX_CTL1, 1, 8'hf8); bus(IDX_CTL1, 0, 0); chk(rd, 32'hf8);
      chk({31'h0, drive_en_q}, 32'h0);
      bus(IDX_CTL1, 1, 8'h00);
      bus(IDX_BRH, 1, 8'h00);
      bus(IDX_BRL, 1, 8'h01);
   endtask : t_regs

   // Config from disabled, one byte out, then idle state after stop
   task t_tx(input logic [7:0] c0, d, input int nb, input logic [10:0] e, input logic idle);
      bus(IDX_CTL0, 1, 8'h00);
      bus(IDX_CTL0, 1, c0);
      bus(IDX_DATA, 1, d);
      far.recv(v, nb);
      chk({21'h0, v}, {21'h0, e});
      repeat (12) @(posedge core_clk);
      bus(IDX_STAT, 0, 0);
      chk({31'h0, rd[ST_TX_IDLE]}, {31'h0, idle});
      chk({31'h0, drive_en_q}, {31'h0, idle});
   endtask : t_tx

   task automatic t_cts;
      int lo = 0;
      bus(IDX_CTL0, 1, 8'h00);
      bus(IDX_CTL0, 1, 8'ha0);
      bus(IDX_DATA, 1, 8'h3c);
      repeat (300) begin
         @(posedge core_clk);
         if (txd_q !== 1'b1) lo++;
      end
      chk(lo, 0);
      cts_n <= 1'b0;
      far.recv(v, 9);
      chk({21'h0, v}, 32'h73c);
      cts_n <= 1'b1;
   endtask : t_cts

   task automatic t_brk;
      int hi = 0;
      bus(IDX_CTL0, 1, 8'h00);
      bus(IDX_CTL0, 1, 8'h80);
      bus(IDX_DATA, 1, 8'hff);
      repeat (200) @(posedge core_clk);
      bus(IDX_STAT, 0, 0);
      chk({31'h0, rd[ST_TX_IDLE]}, 32'h1);
      bus(IDX_CTL0, 1, 8'h84);
      repeat (250) begin
         @(posedge core_clk);
         if (txd_q !== 1'b0) hi++;
      end
      chk(hi, 0);
      bus(IDX_CTL0, 1, 8'h00);
      repeat (40) @(posedge core_clk);
   endtask : t_brk

   task t_loop;
      bus(IDX_CTL0, 1, 8'hc1);
      bus(IDX_DATA, 1, 8'h5a);
      repeat (220) @(posedge core_clk);
      bus(IDX_DATA, 0, 0); chk(rd, 32'h5a);
      bus(IDX_CTL0, 1, 8'h00);
      bus(IDX_CTL0, 1, 8'h81);
      bus(IDX_DATA, 1, 8'h33);
      repeat (220) @(posedge core_clk);
      bus(IDX_STAT, 0, 0); chk({31'h0, rd[ST_RX_VALID]}, 32'h0);
      bus(IDX_CTL0, 1, 8'h00);
   endtask : t_loop

   // Match address, data, other address, data
   task automatic t_mp(input logic [1:0] m, input int n);
      int base;
      bus(IDX_CTL1, 1, {m[1], 1'b1, m[0], 5'h0});
      bus(IDX_MATCH, 1, 8'h3c);
      bus(IDX_CTL0, 1, 8'h40);
      base = irq_cnt;
      far.send(9'h13c, 9);
      bus(IDX_STAT, 0, 0); chk({31'h0, rd[ST_MP_BIT]}, 32'h1);
      far.send(9'h011, 9);
      bus(IDX_STAT, 0, 0); chk({31'h0, rd[ST_FRAME]}, 32'h1);
      bus(IDX_DATA, 0, 0); chk(rd, 32'h11);
      bus(IDX_STAT, 0, 0); chk({30'h0, rd[6:5]}, 32'h0);
      far.send(9'h155, 9);
      far.send(9'h022, 9);
      repeat (20) @(posedge core_clk);
      chk(irq_cnt - base, n);
      bus(IDX_CTL0, 1, 8'h00);
   endtask : t_mp

   // ---------------------------------------------------------------
   // Sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      t_regs;
      t_tx(8'h80, 8'ha5, 9, 11'h7a5, 1'b1);
      t_tx(8'h82, 8'ha5, 9, 11'h7a5, 1'b0);
      t_tx(8'h90, 8'ha5, 10, 11'h6a5, 1'b1);
      t_tx(8'h98, 8'h07, 10, 11'h607, 1'b1);
      t_cts;
      t_brk;
      t_loop;
      t_mp(MP_ALL, 4);
      t_mp(MP_ADDR, 2);
      t_mp(MP_MATCH_ALL, 2);
      t_mp(MP_MATCH_DATA, 1);
      end_sim;
   end

   initial begin
      repeat (60000) @(posedge core_clk);
      errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      end_sim;
   end
endmodule : uart_ctl_tb_top
`default_nettype wire
